/* File: core/monitor_pkg.sv */
// Shared constants and types of the analog value post-processing monitor.
// Assumes samples arrive as signed 32-bit integers, one channel per beat.
package monitor_pkg;

  localparam int VALUE_W  = 32;
  localparam int LIMIT_W  = 16;
  localparam int FILTER_W = 3;
  localparam int CODE_W   = 16;
  localparam int HP_FRAC  = 16;

  typedef logic signed [VALUE_W-1:0] value_t;

  typedef enum logic [FILTER_W-1:0] {
    FILT_OFF     = 3'b000,
    HP_10HZ      = 3'b001,
    HP_1HZ       = 3'b010,
    HP_0P1HZ     = 3'b011,
    HP_0P01HZ    = 3'b100,
    HP_0P001HZ   = 3'b101
  } filter_t;

  typedef enum logic [1:0] {
    LIMIT_OFF   = 2'b00,
    LIMIT_BELOW = 2'b01,
    LIMIT_ABOVE = 2'b10,
    LIMIT_EQUAL = 2'b11
  } limit_code_t;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_EXEC = 2'b01
  } cmd_state_t;

  // Command codes and masks
  localparam logic [CODE_W-1:0] CMD_RESET_ALL   = 16'h3001;
  localparam logic [CODE_W-1:0] CMD_PEAK_BASE   = 16'h3010;
  localparam logic [CODE_W-1:0] CMD_RANGE_BASE  = 16'h3020;
  localparam logic [CODE_W-1:0] CMD_GROUP_MASK  = 16'hFFF0;
  localparam logic [CODE_W-1:0] CMD_CHAN_MASK   = 16'h000F;

  localparam logic [7:0]  STATUS_BUSY          = 8'hFF;
  localparam logic [7:0]  STATUS_DONE          = 8'h00;
  localparam logic [31:0] ABORT_PARAM_INCOMPAT = 32'h0604_0043;
  localparam logic [31:0] ABORT_NONE           = 32'h0000_0000;

  // Legacy-range thresholds, fixed
  localparam value_t LEGACY_UPPER = 32'h0000_7FFF;
  localparam value_t LEGACY_LOWER = 32'hFFFF_8000;

endpackage

/* File: core/stage_if.sv */
// Carriers between the monitor top and its two stage modules.
// Assumes one clock; all signals are plain levels sampled on clk.
`timescale 1ns/1ns

interface sample_if #(parameter int CH_W = 3);
  logic                      valid;
  logic [CH_W-1:0]           channel;
  monitor_pkg::value_t       value;
  modport src (output valid, output channel, output value);
  modport snk (input valid, input channel, input value);
endinterface

interface limit_if;
  monitor_pkg::value_t       value;
  monitor_pkg::value_t       threshold;
  logic                      enable;
  logic                      invert;
  monitor_pkg::limit_code_t  code;
  modport cmp (input value, input threshold, input enable, input invert, output code);
  modport user (output value, output threshold, output enable, output invert, input code);
endinterface

/* File: core/limit_compare.sv */
// One limit comparator: turns a value and a threshold into a 2-bit code.
// Assumes the caller registers the code; this is pure combinational logic.
`timescale 1ns/1ns

module limit_compare (
  limit_if.cmp lim
);
  import monitor_pkg::*;

  always_comb begin
    if (!lim.enable) begin
      lim.code = LIMIT_OFF;
    end else if (lim.value == lim.threshold) begin
      lim.code = LIMIT_EQUAL;
    end else if (lim.value < lim.threshold) begin
      lim.code = lim.invert ? LIMIT_ABOVE : LIMIT_BELOW;
    end else begin
      lim.code = lim.invert ? LIMIT_BELOW : LIMIT_ABOVE;
    end
  end

endmodule

/* File: core/highpass_stage.sv */
// First-order high-pass on a channel-interleaved sample stream.
// Assumes samples carry a channel index; one cycle of latency.
`timescale 1ns/1ns

module highpass_stage #(
  parameter int NUM_CH        = 8,
  parameter int CH_W          = 3,
  parameter int SHIFT_10HZ    = 4,
  parameter int SHIFT_1HZ     = 7,
  parameter int SHIFT_0P1HZ   = 10,
  parameter int SHIFT_0P01HZ  = 14,
  parameter int SHIFT_0P001HZ = 17
) (
  input  wire logic                                 clk,
  input  wire logic                                 srst,
  input  wire logic [NUM_CH*monitor_pkg::FILTER_W-1:0] filterSetting,
  sample_if.snk                                     inS,
  sample_if.src                                     outS
);
  import monitor_pkg::*;

  localparam int AW = VALUE_W + HP_FRAC;

  // DC estimate per channel, with fraction bits for the slow settings
  logic signed [AW-1:0] dcAcc [NUM_CH];
  filter_t              setting;
  logic signed [AW-1:0] xScaled;
  logic signed [AW:0]   diff;
  logic signed [AW:0]   step;
  logic signed [AW-1:0] next_dcAcc;
  value_t               dcInt;
  int                   shiftBy;

  always_comb begin
    setting    = filter_t'(filterSetting[FILTER_W*inS.channel +: FILTER_W]);
    xScaled    = {inS.value, {HP_FRAC{1'b0}}};
    diff       = {xScaled[AW-1], xScaled} - {dcAcc[inS.channel][AW-1], dcAcc[inS.channel]};
    case (setting)
      HP_10HZ:    shiftBy = SHIFT_10HZ;
      HP_1HZ:     shiftBy = SHIFT_1HZ;
      HP_0P1HZ:   shiftBy = SHIFT_0P1HZ;
      HP_0P01HZ:  shiftBy = SHIFT_0P01HZ;
      HP_0P001HZ: shiftBy = SHIFT_0P001HZ;
      default:    shiftBy = 0;
    endcase
    step       = diff >>> shiftBy;
    next_dcAcc = dcAcc[inS.channel] + step[AW-1:0];
    dcInt      = dcAcc[inS.channel][AW-1:HP_FRAC];
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        dcAcc[c] <= '0;
      end
    end else if (inS.valid) begin
      if (shiftBy == 0) begin
        // Estimate starts from zero when a cut-off is chosen: settles visibly
        dcAcc[inS.channel] <= '0;
      end else begin
        dcAcc[inS.channel] <= next_dcAcc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      outS.valid   <= 1'b0;
      outS.channel <= '0;
      outS.value   <= '0;
    end else begin
      outS.valid <= inS.valid;
      if (inS.valid) begin
        outS.channel <= inS.channel;
        if (shiftBy == 0) begin
          outS.value <= inS.value;
        end else begin
          outS.value <= inS.value - dcInt;
        end
      end
    end
  end

endmodule

/* File: core/analog_value_monitor.sv */
// Top of the per-channel analog value post-processing monitor.
// Assumes a channel-interleaved sample stream and a master driving plain ports.
`timescale 1ns/1ns

module analog_value_monitor #(
  parameter int                  NUM_CH             = 8,
  parameter int                  CH_W               = 3,
  parameter int                  CNT_W              = 16,
  parameter monitor_pkg::value_t NOMINAL_FULL_SCALE = 32'sd30000,
  parameter monitor_pkg::value_t TECH_FULL_SCALE    = 32'sd32200
) (
  input  logic                                    clk,
  input  logic                                    srst,
  input  logic                                    sampleValid,
  input  logic [CH_W-1:0]                         sampleChannel,
  input  monitor_pkg::value_t                     sampleValue,
  input  logic [NUM_CH*monitor_pkg::FILTER_W-1:0] filterSetting,
  input  logic                                    floatInterface,
  input  logic                                    rangeScalerSelect,
  input  logic [NUM_CH-1:0]                       invertLimitCodes,
  input  logic [NUM_CH-1:0]                       limitEnable1,
  input  logic [NUM_CH-1:0]                       limitEnable2,
  input  logic [NUM_CH*monitor_pkg::LIMIT_W-1:0]  limitValue1,
  input  logic [NUM_CH*monitor_pkg::LIMIT_W-1:0]  limitValue2,
  input  logic [NUM_CH-1:0]                       peakClearCtrl,
  input  logic                                    thresholdWrite,
  input  logic [CH_W-1:0]                         thresholdChannel,
  input  monitor_pkg::value_t                     lowerThresholdIn,
  input  monitor_pkg::value_t                     upperThresholdIn,
  input  logic                                    commandWrite,
  input  logic [monitor_pkg::CODE_W-1:0]          commandCode,
  input  logic [CH_W-1:0]                         readChannel,
  output logic                                    resultValid,
  output logic [CH_W-1:0]                         resultChannel,
  output monitor_pkg::value_t                     resultValue,
  output logic                                    overrangeFlag,
  output logic                                    underrangeFlag,
  output logic                                    rangeErrorFlag,
  output monitor_pkg::limit_code_t                limit1Code,
  output monitor_pkg::limit_code_t                limit2Code,
  output logic [7:0]                              commandStatus,
  output logic                                    commandAbort,
  output logic [31:0]                             abortCode,
  output logic                                    thresholdRefused,
  output monitor_pkg::value_t                     positivePeak,
  output monitor_pkg::value_t                     negativePeak,
  output monitor_pkg::value_t                     lowerErrorThreshold,
  output monitor_pkg::value_t                     upperErrorThreshold,
  output logic [CNT_W-1:0]                        underErrorCount,
  output logic [CNT_W-1:0]                        overErrorCount
);
  import monitor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // High-pass stage and limit comparators

  sample_if #(.CH_W(CH_W)) hpIn ();
  sample_if #(.CH_W(CH_W)) hpOut ();
  limit_if                 lim1 ();
  limit_if                 lim2 ();

  assign hpIn.valid   = sampleValid;
  assign hpIn.channel = sampleChannel;
  assign hpIn.value   = sampleValue;

  highpass_stage #(.NUM_CH(NUM_CH), .CH_W(CH_W)) hpStage (
    .clk           (clk),
    .srst          (srst),
    .filterSetting (filterSetting),
    .inS           (hpIn),
    .outS          (hpOut)
  );

  assign lim1.value     = hpOut.value;
  assign lim1.threshold = value_t'(signed'(limitValue1[LIMIT_W*hpOut.channel +: LIMIT_W]));
  assign lim1.enable    = limitEnable1[hpOut.channel];
  assign lim1.invert    = invertLimitCodes[hpOut.channel];
  assign lim2.value     = hpOut.value;
  assign lim2.threshold = value_t'(signed'(limitValue2[LIMIT_W*hpOut.channel +: LIMIT_W]));
  assign lim2.enable    = limitEnable2[hpOut.channel];
  assign lim2.invert    = invertLimitCodes[hpOut.channel];

  limit_compare limCmp1 (.lim(lim1));
  limit_compare limCmp2 (.lim(lim2));

  ////////////////////////////////////////////////////////////////////////////////
  // Mode change detection

  logic primed;
  logic prevFloat;
  logic prevScaler;
  logic ifaceChange;
  logic thresholdReloadAll;
  logic writable;
  value_t defaultUpper;
  value_t defaultLower;

  always_ff @(posedge clk) begin
    if (srst) begin
      primed     <= 1'b0;
      prevFloat  <= 1'b0;
      prevScaler <= 1'b0;
    end else begin
      primed     <= 1'b1;
      prevFloat  <= floatInterface;
      prevScaler <= rangeScalerSelect;
    end
  end

  always_comb begin
    ifaceChange        = primed && (floatInterface != prevFloat);
    // First cycle after reset loads the defaults of the present mode
    thresholdReloadAll = !primed || ifaceChange ||
                         (rangeScalerSelect != prevScaler);
    writable           = floatInterface || rangeScalerSelect;
    if (writable) begin
      defaultUpper = TECH_FULL_SCALE;
      defaultLower = -TECH_FULL_SCALE;
    end else begin
      defaultUpper = LEGACY_UPPER;
      defaultLower = LEGACY_LOWER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command object

  cmd_state_t      cmdState;
  logic [CODE_W-1:0] activeCode;
  logic            codeKnown;
  logic [CODE_W-1:0] reqChan;
  logic [NUM_CH-1:0] cmdPeakClear;
  logic [NUM_CH-1:0] cmdRangeReset;

  always_comb begin
    reqChan   = commandCode & CMD_CHAN_MASK;
    codeKnown = (commandCode == CMD_RESET_ALL) ||
                (((commandCode & CMD_GROUP_MASK) == CMD_PEAK_BASE ||
                  (commandCode & CMD_GROUP_MASK) == CMD_RANGE_BASE) &&
                 reqChan < CODE_W'(NUM_CH));
    for (int c = 0; c < NUM_CH; c++) begin
      cmdPeakClear[c]  = 1'b0;
      cmdRangeReset[c] = 1'b0;
      if (cmdState == CMD_EXEC) begin
        if (activeCode == CMD_RESET_ALL) begin
          cmdPeakClear[c]  = 1'b1;
          cmdRangeReset[c] = 1'b1;
        end else if ((activeCode & CMD_CHAN_MASK) == CODE_W'(c)) begin
          cmdPeakClear[c]  = (activeCode & CMD_GROUP_MASK) == CMD_PEAK_BASE;
          cmdRangeReset[c] = (activeCode & CMD_GROUP_MASK) == CMD_RANGE_BASE;
        end
      end
    end
  end

  // Requests during execution are dropped; the master must wait
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdState      <= CMD_IDLE;
      activeCode    <= '0;
      commandStatus <= STATUS_DONE;
      commandAbort  <= 1'b0;
      abortCode     <= ABORT_NONE;
    end else begin
      commandAbort <= 1'b0;
      case (cmdState)
        CMD_IDLE: begin
          if (commandWrite && codeKnown) begin
            activeCode    <= commandCode;
            commandStatus <= STATUS_BUSY;
            cmdState      <= CMD_EXEC;
          end else if (commandWrite) begin
            commandAbort <= 1'b1;
            abortCode    <= ABORT_PARAM_INCOMPAT;
          end
        end
        CMD_EXEC: begin
          commandStatus <= STATUS_DONE;
          cmdState      <= CMD_IDLE;
        end
        default: begin
          cmdState <= CMD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peak hold

  value_t          posPeak [NUM_CH];
  value_t          negPeak [NUM_CH];
  logic [NUM_CH-1:0] peakLoaded;
  logic [NUM_CH-1:0] prevPeakCtrl;
  logic [NUM_CH-1:0] peakClear;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      peakClear[c] = (peakClearCtrl[c] && !prevPeakCtrl[c]) ||
                     cmdPeakClear[c] || ifaceChange;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prevPeakCtrl <= '0;
    end else begin
      prevPeakCtrl <= peakClearCtrl;
    end
  end

  // A sample in the clearing cycle becomes the first value of the new record
  always_ff @(posedge clk) begin
    if (srst) begin
      peakLoaded <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        posPeak[c] <= '0;
        negPeak[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (hpOut.valid && hpOut.channel == CH_W'(c)) begin
          if (peakClear[c] || !peakLoaded[c]) begin
            posPeak[c]    <= hpOut.value;
            negPeak[c]    <= hpOut.value;
            peakLoaded[c] <= 1'b1;
          end else begin
            if (hpOut.value > posPeak[c]) begin
              posPeak[c] <= hpOut.value;
            end
            if (hpOut.value < negPeak[c]) begin
              negPeak[c] <= hpOut.value;
            end
          end
        end else if (peakClear[c]) begin
          peakLoaded[c] <= 1'b0;
          posPeak[c]    <= '0;
          negPeak[c]    <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Range error thresholds and counters

  value_t          lowerThr [NUM_CH];
  value_t          upperThr [NUM_CH];
  logic [CNT_W-1:0] underCnt [NUM_CH];
  logic [CNT_W-1:0] overCnt  [NUM_CH];
  logic [NUM_CH-1:0] wasUnder;
  logic [NUM_CH-1:0] wasOver;
  logic            belowErr;
  logic            aboveErr;

  always_comb begin
    belowErr = hpOut.value < lowerThr[hpOut.channel];
    aboveErr = hpOut.value > upperThr[hpOut.channel];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      thresholdRefused <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        lowerThr[c] <= LEGACY_LOWER;
        upperThr[c] <= LEGACY_UPPER;
      end
    end else begin
      thresholdRefused <= thresholdWrite && !writable;
      for (int c = 0; c < NUM_CH; c++) begin
        if (thresholdReloadAll || cmdRangeReset[c]) begin
          lowerThr[c] <= defaultLower;
          upperThr[c] <= defaultUpper;
        end else if (thresholdWrite && writable && thresholdChannel == CH_W'(c)) begin
          lowerThr[c] <= lowerThresholdIn;
          upperThr[c] <= upperThresholdIn;
        end
      end
    end
  end

  // A crossing is counted once, on entry into the error zone
  always_ff @(posedge clk) begin
    if (srst) begin
      wasUnder <= '0;
      wasOver  <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        underCnt[c] <= '0;
        overCnt[c]  <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (hpOut.valid && hpOut.channel == CH_W'(c)) begin
          wasUnder[c] <= belowErr;
          wasOver[c]  <= aboveErr;
          if (cmdRangeReset[c] || ifaceChange) begin
            underCnt[c] <= CNT_W'(belowErr && !wasUnder[c]);
            overCnt[c]  <= CNT_W'(aboveErr && !wasOver[c]);
          end else begin
            underCnt[c] <= underCnt[c] + CNT_W'(belowErr && !wasUnder[c]);
            overCnt[c]  <= overCnt[c] + CNT_W'(aboveErr && !wasOver[c]);
          end
        end else if (cmdRangeReset[c] || ifaceChange) begin
          underCnt[c] <= '0;
          overCnt[c]  <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-sample result

  always_ff @(posedge clk) begin
    if (srst) begin
      resultValid    <= 1'b0;
      resultChannel  <= '0;
      resultValue    <= '0;
      overrangeFlag  <= 1'b0;
      underrangeFlag <= 1'b0;
      rangeErrorFlag <= 1'b0;
      limit1Code     <= LIMIT_OFF;
      limit2Code     <= LIMIT_OFF;
    end else begin
      resultValid <= hpOut.valid;
      if (hpOut.valid) begin
        // Value passes unclamped; the flags only report
        resultChannel  <= hpOut.channel;
        resultValue    <= hpOut.value;
        overrangeFlag  <= hpOut.value > NOMINAL_FULL_SCALE;
        underrangeFlag <= hpOut.value < -NOMINAL_FULL_SCALE;
        rangeErrorFlag <= belowErr || aboveErr;
        limit1Code     <= lim1.code;
        limit2Code     <= lim2.code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel readback

  always_ff @(posedge clk) begin
    if (srst) begin
      positivePeak        <= '0;
      negativePeak        <= '0;
      lowerErrorThreshold <= '0;
      upperErrorThreshold <= '0;
      underErrorCount     <= '0;
      overErrorCount      <= '0;
    end else begin
      positivePeak        <= posPeak[readChannel];
      negativePeak        <= negPeak[readChannel];
      lowerErrorThreshold <= lowerThr[readChannel];
      upperErrorThreshold <= upperThr[readChannel];
      underErrorCount     <= underCnt[readChannel];
      overErrorCount      <= overCnt[readChannel];
    end
  end

endmodule

/* File: testbench/fieldbus_master_model.sv */
// Master model: writes command request codes to the monitor.
// Assumes the caller is just after a rising edge of clk.
`timescale 1ns/1ns
module fieldbus_master_model (
  input  wire logic        clk,
  input  wire logic [7:0]  commandStatus,
  output logic             commandWrite,
  output logic [15:0]      commandCode
);
  import monitor_pkg::*;
  initial {commandWrite, commandCode} = '0;
  // Returns just after the edge that took the code
  task automatic issue(input logic [15:0] code);
    while (commandStatus === STATUS_BUSY) begin
      @(posedge clk);
      #1;
    end
    commandWrite = 1'b1;
    commandCode = code;
    @(posedge clk);
    #1;
    commandWrite = 1'b0;
  endtask
endmodule

/* File: testbench/analog_value_monitor_props.sv */
// Checker of the monitor top, bound to every instance.
// Assumes one clock with srst synchronous, active high.
`timescale 1ns/1ns
module analog_value_monitor_props #(
  parameter int                  NUM_CH             = 8,
  parameter int                  CNT_W              = 16,
  parameter monitor_pkg::value_t NOMINAL_FULL_SCALE = 32'sd30000
) (
  input logic                                    clk,
  input logic                                    srst,
  input logic                                    sampleValid,
  input monitor_pkg::value_t                     sampleValue,
  input logic [NUM_CH*monitor_pkg::FILTER_W-1:0] filterSetting,
  input logic                                    floatInterface,
  input logic                                    rangeScalerSelect,
  input logic                                    thresholdWrite,
  input logic                                    commandWrite,
  input logic [monitor_pkg::CODE_W-1:0]          commandCode,
  input logic                                    resultValid,
  input monitor_pkg::value_t                     resultValue,
  input logic                                    overrangeFlag,
  input logic                                    underrangeFlag,
  input logic [7:0]                              commandStatus,
  input logic                                    commandAbort,
  input logic [31:0]                             abortCode,
  input logic                                    thresholdRefused,
  input monitor_pkg::value_t                     positivePeak,
  input monitor_pkg::value_t                     negativePeak,
  input monitor_pkg::value_t                     lowerErrorThreshold,
  input monitor_pkg::value_t                     upperErrorThreshold,
  input logic [CNT_W-1:0]                        underErrorCount,
  input logic [CNT_W-1:0]                        overErrorCount
);
  import monitor_pkg::*;
  logic known;
  logic take;
  assign take = commandWrite && commandStatus != STATUS_BUSY;
  assign known = commandCode == CMD_RESET_ALL || !commandCode[3] &&
                 ((commandCode & CMD_GROUP_MASK) inside {CMD_PEAK_BASE, CMD_RANGE_BASE});
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_BUSY: assert property (take && known |=>
    commandStatus == STATUS_BUSY && !commandAbort ##1 commandStatus == STATUS_DONE)
    else $error("busy pulse wrong");
  AST_ABORT: assert property (take && !known |=>
    commandAbort && abortCode == ABORT_PARAM_INCOMPAT && commandStatus == STATUS_DONE)
    else $error("no abort");
  AST_RANGE: assert property (resultValid |->
    overrangeFlag == (resultValue > NOMINAL_FULL_SCALE) &&
    underrangeFlag == (resultValue < -NOMINAL_FULL_SCALE))
    else $error("range flags wrong");
  AST_REFUSE: assert property (thresholdWrite && !floatInterface && !rangeScalerSelect
    |=> thresholdRefused) else $error("write not refused");
  AST_ACCEPT: assert property (thresholdWrite && (floatInterface || rangeScalerSelect)
    |=> !thresholdRefused) else $error("threshold write refused");
  AST_LEGACY: assert property ((!floatInterface && !rangeScalerSelect)[*4] |->
    upperErrorThreshold == LEGACY_UPPER && lowerErrorThreshold == LEGACY_LOWER)
    else $error("legacy thresholds wrong");
  AST_BYPASS: assert property (sampleValid && filterSetting == '0 ##1 filterSetting == '0
    |-> ##1 resultValid && resultValue == $past(sampleValue, 2))
    else $error("bypass result wrong");
  AST_CLR_ALL: assert property (!sampleValid ##1 take && commandCode == CMD_RESET_ALL
    && !sampleValid ##1 !sampleValid |-> ##3 positivePeak == 0 && negativePeak == 0 &&
    underErrorCount == 0 && overErrorCount == 0) else $error("reset all incomplete");
endmodule
bind analog_value_monitor analog_value_monitor_props #(.NUM_CH(NUM_CH), .CNT_W(CNT_W),
  .NOMINAL_FULL_SCALE(NOMINAL_FULL_SCALE)) props (.*);

/* File: testbench/test_analog_value_monitor.sv */
// Self-checking bench of the monitor, one task per scenario.
// Assumes the package, design and master model compile first.
`timescale 1ns/1ns
module test_analog_value_monitor;
  import monitor_pkg::*;
  localparam value_t NFS = 32'sd30000;
  localparam value_t TFS = 32'sd32200;
  logic clk = 1'b0, srst = 1'b1, sampleValid = 1'b0, thresholdWrite = 1'b0;
  logic floatInterface = 1'b0, rangeScalerSelect = 1'b0, commandWrite, seen;
  logic [2:0] sampleChannel = 3'h0, thresholdChannel = 3'h2, readChannel = 3'h0, resultChannel;
  value_t sampleValue = 0, lowerThresholdIn = -32'sd100, upperThresholdIn = 32'sd100;
  logic [23:0] filterSetting = 24'h00_0000;
  logic [7:0] invertLimitCodes = '0, limitEnable1 = '0, limitEnable2 = '0, peakClearCtrl = '0;
  logic [127:0] limitValue1 = '0, limitValue2 = '0;
  logic [15:0] commandCode, underErrorCount, overErrorCount;
  logic [7:0] commandStatus;
  logic [31:0] abortCode;
  logic resultValid, overrangeFlag, underrangeFlag, rangeErrorFlag, commandAbort, thresholdRefused;
  limit_code_t limit1Code, limit2Code;
  value_t resultValue, positivePeak, negativePeak, lowerErrorThreshold, upperErrorThreshold;
  int fail_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  analog_value_monitor dut (.*);
  fieldbus_master_model m (.*);
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  // Result and readback have both landed on return
  task automatic send(logic [2:0] ch, value_t v);
    sampleChannel = ch;
    sampleValue = v;
    sampleValid = 1'b1;
    step;
    sampleValid = 1'b0;
    repeat (3) step;
  endtask
  task automatic wr_thr;
    thresholdWrite = 1'b1;
    step;
    seen = thresholdRefused;
    thresholdWrite = 1'b0;
    repeat (2) begin
      step;
      seen |= thresholdRefused;
    end
  endtask
  task automatic t_bypass;
    send(3'h0, NFS + 1);
    chk("value", NFS + 1, resultValue);
    chk("over", 1, overrangeFlag);
    send(3'h0, -NFS - 1);
    chk("under", 1, underrangeFlag);
    send(3'h0, NFS);
    chk("over at scale", 0, overrangeFlag);
  endtask
  task automatic t_hp;
    for (int k = 1; k < 6; k++) begin
      filterSetting[2:0] = 3'h0;
      send(3'h0, 1000);
      filterSetting[2:0] = k[2:0];
      send(3'h0, 1000);
      chk("hp first", 1000, resultValue);
    end
    filterSetting[2:0] = 3'h1;
    repeat (63) send(3'h0, 1000);
    chk("hp decay", 1, resultValue < 250);
    filterSetting[2:0] = 3'h0;
  endtask
  task automatic t_peak;
    readChannel = 3'h1;
    send(3'h1, 500);
    send(3'h1, -700);
    send(3'h1, 200);
    chk("pos", 500, positivePeak);
    chk("neg", -700, negativePeak);
    peakClearCtrl[1] = 1'b1;
    repeat (3) step;
    chk("clr", 0, positivePeak);
    peakClearCtrl[1] = 1'b0;
    send(3'h4, 300);
    send(3'h1, 400);
    m.issue(16'h3011);
    chk("busy", 8'hFF, commandStatus);
    step;
    chk("done", 8'h00, commandStatus);
    step;
    chk("ch1", 0, positivePeak);
    readChannel = 3'h4;
    repeat (2) step;
    chk("ch4", 300, positivePeak);
    m.issue(16'h3001);
    repeat (2) step;
    chk("all", 0, positivePeak);
    m.issue(16'h3030);
    chk("abort", 1, commandAbort);
    chk("code", 32'h0604_0043, abortCode);
  endtask
  task automatic t_range;
    readChannel = 3'h2;
    repeat (2) step;
    chk("upper", 32'h0000_7FFF, upperErrorThreshold);
    chk("lower", 32'hFFFF_8000, lowerErrorThreshold);
    wr_thr;
    chk("refused", 1, seen);
    send(3'h2, 40000);
    chk("err", 1, rangeErrorFlag);
    send(3'h2, 40000);
    send(3'h2, 0);
    send(3'h2, 40000);
    chk("over", 2, overErrorCount);
    rangeScalerSelect = 1'b1;
    repeat (3) step;
    chk("ext", TFS, upperErrorThreshold);
    wr_thr;
    chk("ok", 0, seen);
    chk("set", 100, upperErrorThreshold);
    send(3'h2, 150);
    chk("err2", 1, rangeErrorFlag);
    m.issue(16'h3022);
    repeat (2) step;
    chk("back", TFS, upperErrorThreshold);
    chk("cnt", 0, overErrorCount);
    send(3'h2, 40000);
    m.issue(16'h3001);
    repeat (2) step;
    chk("over all", 0, overErrorCount);
    floatInterface = 1'b1;
    repeat (3) step;
    send(3'h2, -40000);
    chk("ucnt", 1, underErrorCount);
    floatInterface = 1'b0;
    repeat (3) step;
    chk("umode", 0, underErrorCount);
    chk("pmode", 0, negativePeak);
    rangeScalerSelect = 1'b0;
  endtask
  task automatic t_limit;
    value_t lv[3] = '{50, 150, 100};
    logic [1:0] lc[6] = '{1, 2, 3, 2, 1, 3};
    limitValue1[63:48] = 16'h0064;
    limitValue2[63:48] = 16'h0064;
    limitEnable1[3] = 1'b1;
    for (int i = 0; i < 6; i++) begin
      invertLimitCodes[3] = i > 2;
      send(3'h3, lv[i % 3]);
      chk("limit1", lc[i], limit1Code);
      chk("limit2 off", 0, limit2Code);
    end
    limitEnable2[3] = 1'b1;
    send(3'h3, 100);
    chk("limit2", 3, limit2Code);
    chk("chan", 3, resultChannel);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    step;
    t_bypass;
    t_hp;
    t_peak;
    t_range;
    t_limit;
    end_of_test;
  end
  // Run needs about 420 cycles
  initial begin
    #400000;
    fail_count++;
    end_of_test;
  end
endmodule
